// ==== eqws_egress_queue.sv ====
// egress queue drop control, transmit scheduler and vid replacement
// assumes one instance per switch port, inputs synchronous to core_clk
`include "eqws_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module eqws_egress_queue #(
    parameter int AVG_CYCLES = `EQWS_AVG_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0][10:0] q_depth,
    input wire eqws_pkg::eqws_pkt_type pkt_in,
    output eqws_pkg::eqws_verdict_type verdict_out,
    input wire logic [1:0] txq_count,
    input wire logic [3:0] q_nonempty,
    input wire logic tx_ready,
    output eqws_pkg::eqws_grant_type grant_out,
    output logic [3:0][1:0] shaper_sel,
    input wire logic [11:0] port_default_vlan_id,
    input wire eqws_pkg::eqws_tag_type tag_in,
    output eqws_pkg::eqws_tag_type tag_out
);
    eqws_pkg::eqws_state_type st_r; // registered state
    eqws_pkg::eqws_state_type st_nxt; // next state
    logic [3:0][10:0] avg_step; // next average per queue
    logic [10:0] avg_q; // addressed queue average
    logic [10:0] min_q; // addressed queue minimum
    logic [10:0] max_q; // addressed queue maximum
    logic [5:0] ctl_q; // addressed queue control bits
    logic [10:0] span; // max minus min, zero if inverted
    logic [10:0] excess; // avg minus min
    logic [20:0] lhs; // random sample scaled by span
    logic [21:0] rhs; // excess scaled by multiplier
    logic inhibit; // colour inhibit hit
    logic below; // average under minimum
    logic above; // average over maximum
    logic rand_hit; // random drop chosen
    logic drop_now; // verdict before registering
    logic [3:0] q_mask; // enabled queues
    logic [3:0] ready_q; // enabled and waiting
    logic [1:0] hi_q; // highest waiting queue
    logic [1:0] rr_next; // next waiting queue in turn
    logic rr_found; // rr_next is valid
    logic [1:0] cand; // loop candidate
    logic tick; // averaging enable pulse
    logic flush_edge; // rising flush bit on write

    // running average per queue, 1/8 step toward depth, rounded up
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_avg
            logic up;
            logic [10:0] diff;
            logic [10:0] inc;
            assign up = q_depth[gi] > st_r.avg[gi];
            assign diff = up ? q_depth[gi] - st_r.avg[gi]
                             : st_r.avg[gi] - q_depth[gi];
            assign inc = 11'((12'(diff) + 12'h007) >> `EQWS_AVG_SHIFT);
            assign avg_step[gi] = up ? st_r.avg[gi] + inc
                                     : st_r.avg[gi] - inc;
        end
    endgenerate

    // operands of the admission decision for the requested queue
    assign avg_q = st_r.avg[pkt_in.queue];
    assign min_q = st_r.min_th[pkt_in.queue];
    assign max_q = st_r.max_th[pkt_in.queue];
    assign ctl_q = st_r.ctl[pkt_in.queue];
    assign span = (max_q > min_q) ? max_q - min_q : 11'h000;
    assign excess = (avg_q > min_q) ? avg_q - min_q : 11'h000;
    // chance = excess*mult / (1024*span); avoids a divider
    assign lhs = 21'(st_r.lfsr[9:0]) * 21'(span);
    assign rhs = 22'(excess) * 22'(st_r.mult[pkt_in.queue]);
    // reserved colour is treated as red
    assign inhibit = ctl_q[`EQWS_C_INH_ALL]
        | (ctl_q[`EQWS_C_INH_YELRED]
            && pkt_in.colour != eqws_pkg::EQWS_GREEN)
        | (ctl_q[`EQWS_C_R] && (pkt_in.colour == eqws_pkg::EQWS_RED
            || pkt_in.colour == eqws_pkg::EQWS_COL_RSV));
    assign below = avg_q < min_q;
    assign above = avg_q > max_q;
    assign rand_hit = ctl_q[`EQWS_C_RAND] && (22'(lhs) < rhs);
    // above maximum: drop-all forces, otherwise multiplier decides
    assign drop_now = !inhibit && !below
        && (above ? (ctl_q[`EQWS_C_ALL] || rand_hit)
                  : rand_hit);

    // queues taking part: one, two or four
    assign q_mask = (txq_count == 2'd2) ? 4'hF
                  : (txq_count == 2'd1) ? 4'h3 : 4'h1;
    assign ready_q = q_mask & q_nonempty;
    // highest waiting queue wins in strict mode
    assign hi_q = ready_q[3] ? 2'd3 : ready_q[2] ? 2'd2
                : ready_q[1] ? 2'd1 : 2'd0;
    // next waiting queue below the current one, wrapping round
    always_comb
    begin
        rr_next = st_r.wrr_q;
        rr_found = 1'b0;
        cand = st_r.wrr_q;
        for (int k = 1; k < 4; k++)
        begin
            cand = 2'(st_r.wrr_q - 2'(k));
            if (!rr_found && ready_q[cand])
            begin
                rr_next = cand;
                rr_found = 1'b1;
            end
        end
    end

    // averaging enable: one pulse every AVG_CYCLES, a slow rate without
    // a second clock
    assign tick = st_r.tick_cnt == 16'(AVG_CYCLES - 1);
    // edge taken against the stored bit of the indexed queue, so writing
    // a steady 1 again leaves the counter alone
    assign flush_edge = reg_wr && reg_addr == `EQWS_OFS_MON
        && reg_wdata[30] && !st_r.ctl[st_r.qidx][`EQWS_C_FLUSH];

    // whole next-state function
    always_comb
    begin
        st_nxt = st_r;
        // lfsr steps every cycle; its low ten bits are the random sample,
        // cheap but with a period far short of true randomness
        st_nxt.lfsr = {st_r.lfsr[14:0], st_r.lfsr[15] ^ st_r.lfsr[13]
            ^ st_r.lfsr[12] ^ st_r.lfsr[10]};
        st_nxt.verdict = '0;
        st_nxt.grant = '0;
        st_nxt.tag = '0;
        st_nxt.rdata = 32'h0000_0000;
        // averaging divider and update
        st_nxt.tick_cnt = tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;
        if (tick)
        begin
            st_nxt.avg = avg_step;
        end
        // register writes, indexed ones land in the selected queue
        if (reg_wr)
        begin
            case (reg_addr)
                `EQWS_OFS_THRESH:
                begin
                    st_nxt.max_th[st_r.qidx] = reg_wdata[26:16];
                    st_nxt.min_th[st_r.qidx] = reg_wdata[10:0];
                end
                `EQWS_OFS_MULT:
                begin
                    // average field ignored on write
                    st_nxt.mult[st_r.qidx] = reg_wdata[26:16];
                end
                `EQWS_OFS_MON:
                begin
                    st_nxt.ctl[st_r.qidx] = reg_wdata[31:26];
                    if (flush_edge)
                    begin
                        st_nxt.cnt[st_r.qidx] = 24'h000000;
                    end
                end
                `EQWS_OFS_QIDX:
                begin
                    st_nxt.qidx = reg_wdata[1:0];
                end
                `EQWS_OFS_QIDX_B:
                begin
                    // byte alias carries bits 7:0 in the low lane
                    st_nxt.qidx = reg_wdata[1:0];
                end
                `EQWS_OFS_VID:
                begin
                    st_nxt.vid_rep = reg_wdata[0];
                end
                `EQWS_OFS_POLICY:
                begin
                    st_nxt.sched[st_r.qidx] = reg_wdata[7:6];
                    st_nxt.shaper[st_r.qidx] = reg_wdata[5:4];
                end
                `EQWS_OFS_WEIGHT:
                begin
                    st_nxt.weight[st_r.qidx] = reg_wdata[6:0];
                end
                default:
                begin
                    // unmapped writes are dropped
                end
            endcase
        end
        // register reads, reserved bits and unmapped offsets read zero
        if (reg_rd)
        begin
            case (reg_addr)
                `EQWS_OFS_THRESH:
                    st_nxt.rdata = {5'h00, st_r.max_th[st_r.qidx],
                        5'h00, st_r.min_th[st_r.qidx]};
                `EQWS_OFS_MULT:
                    st_nxt.rdata = {5'h00, st_r.mult[st_r.qidx],
                        5'h00, st_r.avg[st_r.qidx]};
                `EQWS_OFS_MON:
                    st_nxt.rdata = {st_r.ctl[st_r.qidx], 2'h0,
                        st_r.cnt[st_r.qidx]};
                `EQWS_OFS_QIDX, `EQWS_OFS_QIDX_B:
                    st_nxt.rdata = {30'h00000000, st_r.qidx};
                `EQWS_OFS_VID:
                    st_nxt.rdata = {31'h00000000, st_r.vid_rep};
                `EQWS_OFS_POLICY:
                    st_nxt.rdata = {24'h000000, st_r.sched[st_r.qidx],
                        st_r.shaper[st_r.qidx], 4'h0};
                `EQWS_OFS_WEIGHT:
                    st_nxt.rdata = {25'h0000000, st_r.weight[st_r.qidx]};
                default:
                    st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // admission verdict; a drop counts after any flush, so it survives
        if (pkt_in.valid)
        begin
            st_nxt.verdict.valid = 1'b1;
            st_nxt.verdict.queue = pkt_in.queue;
            st_nxt.verdict.drop = drop_now;
            if (drop_now)
            begin
                st_nxt.cnt[pkt_in.queue] =
                    st_nxt.cnt[pkt_in.queue] + 24'h000001;
            end
        end
        // transmit scheduler, policy taken from queue 0's entry
        // one policy per port keeps the arbiter a single decision path
        if (tx_ready && ready_q != 4'h0)
        begin
            st_nxt.grant.valid = 1'b1;
            if (txq_count == 2'd0)
            begin
                st_nxt.grant.queue = 2'd0;
            end
            else if (st_r.sched[0] == eqws_pkg::EQWS_SCHED_WRR)
            begin
                // stay while weight allows, else move on in turn
                if (ready_q[st_r.wrr_q]
                    && st_r.wrr_used < st_r.weight[st_r.wrr_q])
                begin
                    st_nxt.grant.queue = st_r.wrr_q;
                    st_nxt.wrr_used = st_r.wrr_used + 7'h01;
                end
                else
                begin
                    st_nxt.grant.queue = rr_found ? rr_next
                                                  : st_r.wrr_q;
                    st_nxt.wrr_q = rr_found ? rr_next : st_r.wrr_q;
                    st_nxt.wrr_used = 7'h01;
                end
            end
            else
            begin
                // strict, also for the reserved codes
                st_nxt.grant.queue = hi_q;
            end
        end
        // egress vid replacement
        if (tag_in.valid)
        begin
            st_nxt.tag = tag_in;
            if (st_r.vid_rep && tag_in.dtag
                && tag_in.outer_vid != 12'h000)
            begin
                st_nxt.tag.outer_vid = port_default_vlan_id;
            end
            else if (st_r.vid_rep && !tag_in.dtag
                && tag_in.inner_vid != 12'h000)
            begin
                st_nxt.tag.inner_vid = port_default_vlan_id;
            end
        end
        // synchronous reset to documented defaults
        if (sys_rst)
        begin
            st_nxt = '0;
            st_nxt.lfsr = 16'hACE1;
            for (int q = 0; q < 4; q++)
            begin
                st_nxt.max_th[q] = `EQWS_RST_MAX;
                st_nxt.min_th[q] = `EQWS_RST_MIN;
                st_nxt.mult[q] = `EQWS_RST_MULT;
                st_nxt.sched[q] = `EQWS_RST_SCHED;
                st_nxt.shaper[q] = `EQWS_RST_SHAPER;
                st_nxt.weight[q] = `EQWS_RST_WEIGHT;
            end
        end
    end

    // single state register
    always_ff @(posedge core_clk)
    begin
        st_r <= st_nxt;
    end

    // outputs straight from state
    assign reg_rdata = st_r.rdata;
    assign verdict_out = st_r.verdict;
    assign grant_out = st_r.grant;
    assign shaper_sel = st_r.shaper;
    assign tag_out = st_r.tag;

    // checks on the drop, scheduler and tag paths
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_keep_below_min: assert property (
        pkt_in.valid && below |=> verdict_out.valid && !verdict_out.drop)
        else $error("drop below minimum threshold");
    a_all_colour_inhibit: assert property (
        pkt_in.valid && ctl_q[`EQWS_C_INH_ALL] |=> !verdict_out.drop)
        else $error("drop despite all-colour inhibit");
    a_yel_red_inhibit: assert property (
        pkt_in.valid && ctl_q[`EQWS_C_INH_YELRED]
        && pkt_in.colour != eqws_pkg::EQWS_GREEN |=> !verdict_out.drop)
        else $error("yellow or red dropped while inhibited");
    a_red_inhibit: assert property (
        pkt_in.valid && ctl_q[`EQWS_C_R]
        && pkt_in.colour == eqws_pkg::EQWS_RED |=> !verdict_out.drop)
        else $error("red dropped while inhibited");
    a_drop_all_over: assert property (
        pkt_in.valid && above && ctl_q[`EQWS_C_ALL] && !inhibit
        |=> verdict_out.drop)
        else $error("drop-all did not drop above maximum");
    a_no_random_drop: assert property (
        pkt_in.valid && !ctl_q[`EQWS_C_RAND] && !above
        |=> !verdict_out.drop)
        else $error("random drop while disabled");
    a_flush_clears: assert property (
        flush_edge && !pkt_in.valid
        |=> st_r.cnt[$past(st_r.qidx)] == 24'h000000)
        else $error("flush edge left counter non-zero");
    a_vid_replace: assert property (
        tag_in.valid && st_r.vid_rep && !tag_in.dtag
        && tag_in.inner_vid != 12'h000
        |=> tag_out.inner_vid == $past(port_default_vlan_id))
        else $error("vid not replaced");
    a_strict_top: assert property (
        tx_ready && txq_count == 2'd2 && q_nonempty[3]
        && st_r.sched[0] == eqws_pkg::EQWS_SCHED_STRICT
        |=> grant_out.valid && grant_out.queue == 2'd3)
        else $error("strict priority skipped queue 3");
    a_no_idle_grant: assert property (
        !tx_ready || ready_q == 4'h0 |=> !grant_out.valid)
        else $error("grant issued with nothing waiting");
endmodule : eqws_egress_queue
`default_nettype wire

// ==== eqws_egress_queue_tb.sv ====
// self-checking bench for the egress queue drop and scheduling block
// assumes the partner model drives depths, backlog and port readiness
`include "eqws_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module eqws_egress_queue_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0][10:0] q_depth;
    eqws_pkg::eqws_pkt_type pkt_in = '0;
    eqws_pkg::eqws_verdict_type verdict_out;
    logic [1:0] txq_count = 2'h2; // four queues
    logic [3:0] q_nonempty;
    logic tx_ready;
    eqws_pkg::eqws_grant_type grant_out;
    logic [3:0][1:0] shaper_sel;
    logic [11:0] port_default_vlan_id = 12'h3C5; // default vid of the port
    eqws_pkg::eqws_tag_type tag_in = '0;
    eqws_pkg::eqws_tag_type tag_out;
    logic [3:0][10:0] depth_set = '0;
    logic [3:0][7:0] load_cnt = '0;
    logic load = 1'b0;
    logic [3:0] tx_gap = 4'h2;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h1C; // fixed start keeps runs repeatable
    logic [1:0] gq[$]; // grants seen in order
    eqws_egress_queue #(.AVG_CYCLES(4)) eqws_egress_queue_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .q_depth(q_depth), .pkt_in(pkt_in),
        .verdict_out(verdict_out), .txq_count(txq_count),
        .q_nonempty(q_nonempty), .tx_ready(tx_ready),
        .grant_out(grant_out), .shaper_sel(shaper_sel),
        .port_default_vlan_id(port_default_vlan_id),
        .tag_in(tag_in), .tag_out(tag_out));
    eqws_qm_model eqws_qm_model_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .depth_set(depth_set),
        .load_cnt(load_cnt), .load(load), .tx_gap(tx_gap),
        .grant_out(grant_out), .q_depth(q_depth),
        .q_nonempty(q_nonempty), .tx_ready(tx_ready));
    // free-running core clock, 100 MHz
    always #5 core_clk = ~core_clk;
    // collect every grant pulse
    always @(posedge core_clk)
        if (grant_out.valid === 1'b1)
            gq.push_back(grant_out.queue);
    // hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            stop_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected admission: inhibits first, then drop-all or full random
    function automatic logic drop_exp(logic [5:0] c, logic [1:0] col);
        logic inh;
        inh = c[3] | (c[2] & (col != 2'h0)) | (c[1] & col[1]);
        return !inh & (c[0] | c[5]);
    endfunction : drop_exp
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask : rchk
    task automatic pkt(logic [1:0] q, logic [1:0] c, logic e);
        @(posedge core_clk);
        pkt_in <= {1'b1, q, c};
        @(posedge core_clk);
        pkt_in <= '0;
        #1 chk("verdict", 32'({1'b1, q, e}), 32'(verdict_out));
    endtask : pkt
    task automatic tag(logic dt, logic [11:0] ov, iv, eo, ei);
        @(posedge core_clk);
        tag_in <= {1'b1, dt, ov, iv};
        @(posedge core_clk);
        tag_in <= '0;
        #1 chk("tag", 32'({1'b1, dt, eo, ei}), 32'(tag_out));
    endtask : tag
    // load backlog, wait for n grants, then a margin for extra ones
    task automatic run(logic [31:0] cnts, int n);
        gq.delete();
        tx_gap <= 4'(2 + rnd() % 4); // prompt or slow port
        load_cnt <= cnts;
        load <= 1'b1;
        @(posedge core_clk);
        load <= 1'b0;
        for (int t = 0; t < 600 && gq.size() < n; t++)
            @(posedge core_clk);
        repeat (20) @(posedge core_clk);
    endtask : run
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial
    begin
        logic [5:0] c;
        logic [1:0] col;
        logic [3:0][7:0] k;
        int n, hq;
        int hist[4];
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        // reset values, then random per-queue contents via both index views
        for (int q = 0; q < 4; q++)
        begin
            wr(q[0] ? `EQWS_OFS_QIDX_B : `EQWS_OFS_QIDX, 32'(q));
            rchk("thr", `EQWS_OFS_THRESH, 32'h0080_0009);
            rchk("mul", `EQWS_OFS_MULT, 32'h0010_0000);
            rchk("mon", `EQWS_OFS_MON, 32'h0);
            rchk("pol", `EQWS_OFS_POLICY, 32'h80);
            rchk("wgt", `EQWS_OFS_WEIGHT, 32'h01);
            rchk("idx", `EQWS_OFS_QIDX, 32'(q));
            wr(`EQWS_OFS_THRESH, rnd());
            wr(`EQWS_OFS_POLICY, {26'h0, 2'(q % 3), 4'hF});
        end
        for (int q = 3; q >= 0; q--)
        begin
            wr(`EQWS_OFS_QIDX, 32'(q));
            rchk("pol", `EQWS_OFS_POLICY, {26'h0, 2'(q % 3), 4'h0});
        end
        chk("shaper", 32'h24, 32'(shaper_sel));
        rchk("unmapped", 12'h850, 32'h0);
        wr(`EQWS_OFS_VID, 32'hFFFF_FFFF);
        rchk("vid", `EQWS_OFS_VID, 32'h1);
        tag(1'b0, 12'h00A, 12'h005, 12'h00A, port_default_vlan_id);
        tag(1'b0, 12'h00A, 12'h000, 12'h00A, 12'h000);
        tag(1'b1, 12'h007, 12'h005, port_default_vlan_id, 12'h005);
        wr(`EQWS_OFS_VID, 32'h0);
        tag(1'b0, 12'h00A, 12'h005, 12'h00A, 12'h005);
        // queue 0 driven far above its maximum
        wr(`EQWS_OFS_QIDX, 32'h0);
        wr(`EQWS_OFS_THRESH, 32'h0004_0002);
        depth_set[0] <= 11'h7FF;
        repeat (600) @(posedge core_clk);
        wr(`EQWS_OFS_MULT, 32'h07FF_0000);
        rchk("avg", `EQWS_OFS_MULT, 32'h07FF_07FF);
        n = 0;
        for (int i = 0; i < 48; i++)
        begin
            c = 6'(rnd()) & 6'h2F;
            col = 2'(rnd());
            wr(`EQWS_OFS_MON, {c, 26'h0});
            pkt(2'h0, col, drop_exp(c, col));
            n += drop_exp(c, col);
        end
        rchk("cnt", `EQWS_OFS_MON, {c, 2'h0, 24'(n)});
        wr(`EQWS_OFS_MON, 32'h4400_0000);
        rchk("flush", `EQWS_OFS_MON, 32'h4400_0000);
        pkt(2'h0, 2'h2, 1'b1);
        wr(`EQWS_OFS_MON, 32'h4400_0000);
        rchk("held", `EQWS_OFS_MON, 32'h4400_0001);
        // average between thresholds: drop-all idle, random alone decides
        wr(`EQWS_OFS_THRESH, 32'h07FF_0002);
        wr(`EQWS_OFS_MON, 32'h0400_0000);
        pkt(2'h0, 2'h2, 1'b0);
        wr(`EQWS_OFS_MON, 32'h8000_0000);
        pkt(2'h0, 2'h0, 1'b1);
        // queue 1 stays empty, so below its minimum nothing is dropped
        wr(`EQWS_OFS_QIDX, 32'h1);
        wr(`EQWS_OFS_THRESH, 32'h0080_0009);
        wr(`EQWS_OFS_MON, 32'h8400_0000);
        pkt(2'h1, 2'h2, 1'b0);
        // strict priority with a random backlog
        wr(`EQWS_OFS_QIDX, 32'h0);
        wr(`EQWS_OFS_POLICY, 32'h0);
        k = {8'(rnd() % 3), 8'(rnd() % 3), 8'(rnd() % 3), 8'(rnd() % 3)};
        n = k[0] + k[1] + k[2] + k[3];
        run(k, n);
        chk("ngrant", 32'(n), 32'(gq.size()));
        for (int i = 0; i < n; i++)
        begin
            for (int j = 0; j < 4; j++)
                if (k[j] != 8'h00)
                    hq = j;
            chk("strict", 32'(hq), 32'(gq[i]));
            k[hq] = k[hq] - 8'h01;
        end
        // weighted round robin, weights 1 to 4
        for (int q = 0; q < 4; q++)
        begin
            wr(`EQWS_OFS_QIDX, 32'(q));
            wr(`EQWS_OFS_WEIGHT, 32'(q + 1));
        end
        wr(`EQWS_OFS_QIDX, 32'h0);
        wr(`EQWS_OFS_POLICY, 32'h80);
        run(32'h1E1E_1E1E, 30);
        hist = '{0, 0, 0, 0};
        for (int i = 10; i < 20; i++)
            hist[gq[i]]++;
        for (int q = 0; q < 4; q++)
            chk("wrr", 32'(q + 1), 32'(hist[q]));
        run(32'h0, 0);
        // one queue only: higher queues never served
        txq_count <= 2'h0;
        run(32'h0101_0100, 1);
        chk("single", 32'h0, 32'(gq.size()));
        stop_test();
    end
endmodule : eqws_egress_queue_tb
`default_nettype wire

// ==== eqws_pkg.sv ====
// types for the egress queue drop and scheduling block
// assumes four queues per port and an 11-bit queue size scale
package eqws_pkg;
    // scheduler codes; 01 and 11 are reserved
    typedef enum logic [1:0] {
        EQWS_SCHED_STRICT = 2'b00,
        EQWS_SCHED_RSV1 = 2'b01,
        EQWS_SCHED_WRR = 2'b10,
        EQWS_SCHED_RSV3 = 2'b11
    } eqws_sched_type;
    // packet colour from the policer
    typedef enum logic [1:0] {
        EQWS_GREEN = 2'b00,
        EQWS_YELLOW = 2'b01,
        EQWS_RED = 2'b10,
        EQWS_COL_RSV = 2'b11
    } eqws_colour_type;
    // admission request from the queue manager
    typedef struct packed {
        logic valid;
        logic [1:0] queue;
        eqws_colour_type colour;
    } eqws_pkt_type;
    // admission answer
    typedef struct packed {
        logic valid;
        logic [1:0] queue;
        logic drop;
    } eqws_verdict_type;
    // egress tag in and out
    typedef struct packed {
        logic valid;
        logic dtag;
        logic [11:0] outer_vid;
        logic [11:0] inner_vid;
    } eqws_tag_type;
    // transmit grant
    typedef struct packed {
        logic valid;
        logic [1:0] queue;
    } eqws_grant_type;
    // complete block state
    typedef struct packed {
        logic [3:0][10:0] max_th;
        logic [3:0][10:0] min_th;
        logic [3:0][10:0] mult;
        logic [3:0][10:0] avg;
        logic [3:0][5:0] ctl;
        logic [3:0][23:0] cnt;
        logic [3:0][1:0] sched;
        logic [3:0][1:0] shaper;
        logic [3:0][6:0] weight;
        logic [1:0] qidx;
        logic vid_rep;
        logic [31:0] rdata;
        logic [15:0] lfsr;
        logic [15:0] tick_cnt;
        eqws_verdict_type verdict;
        eqws_grant_type grant;
        logic [1:0] wrr_q;
        logic [6:0] wrr_used;
        eqws_tag_type tag;
    } eqws_state_type;
endpackage : eqws_pkg

// ==== eqws_qm_model.sv ====
// queue manager and transmit path model facing the egress queue block
// assumes grants arrive as one-cycle pulses synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module eqws_qm_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0][10:0] depth_set,
    input wire logic [3:0][7:0] load_cnt,
    input wire logic load,
    input wire logic [3:0] tx_gap,
    input wire eqws_pkg::eqws_grant_type grant_out,
    output logic [3:0][10:0] q_depth,
    output logic [3:0] q_nonempty,
    output logic tx_ready
);
    logic [3:0][7:0] cnt_r; // packets waiting per queue
    logic [3:0] gap_r; // idle cycles left before the port is ready
    // instantaneous depth is whatever the bench asks for
    assign q_depth = depth_set;
    // a queue is waiting while its packet count is non-zero
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            q_nonempty[i] = (cnt_r[i] != 8'h00);
        end
    end
    // ready for one cycle, then idle so a grant lands before the next ask
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || load)
        begin
            cnt_r <= load ? load_cnt : '0;
            gap_r <= 4'h0;
        end
        else
        begin
            // a granted packet leaves its queue
            if (grant_out.valid)
                cnt_r[grant_out.queue] <= cnt_r[grant_out.queue] - 8'h01;
            gap_r <= (gap_r == 4'h0) ? tx_gap : gap_r - 4'h1;
        end
    end
    assign tx_ready = (gap_r == 4'h0) && !sys_rst;
endmodule : eqws_qm_model
`default_nettype wire

// ==== eqws_regs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 12-bit offset inside one switch port's register space
`ifndef EQWS_REGS_SVH
`define EQWS_REGS_SVH
// register offsets within the port space
`define EQWS_OFS_THRESH 12'h840
`define EQWS_OFS_MULT 12'h844
`define EQWS_OFS_MON 12'h848
`define EQWS_OFS_QIDX 12'h900
`define EQWS_OFS_QIDX_B 12'h903
`define EQWS_OFS_VID 12'h904
`define EQWS_OFS_POLICY 12'h914
`define EQWS_OFS_WEIGHT 12'h915
// field positions
`define EQWS_HI_MSB 26
`define EQWS_HI_LSB 16
`define EQWS_LO_MSB 10
`define EQWS_LO_LSB 0
`define EQWS_CTL_MSB 31
`define EQWS_CTL_LSB 26
`define EQWS_CNT_MSB 23
`define EQWS_SCHED_MSB 7
`define EQWS_SCHED_LSB 6
`define EQWS_SHAPER_MSB 5
`define EQWS_SHAPER_LSB 4
`define EQWS_WEIGHT_MSB 6
// bit positions inside the six stored control bits (31:26)
`define EQWS_C_RAND 5
`define EQWS_C_FLUSH 4
`define EQWS_C_INH_ALL 3
`define EQWS_C_INH_YELRED 2
`define EQWS_C_R 1
`define EQWS_C_ALL 0
// reset values
`define EQWS_RST_MAX 11'h080
`define EQWS_RST_MIN 11'h009
`define EQWS_RST_MULT 11'h010
`define EQWS_RST_SCHED 2'h2
`define EQWS_RST_SHAPER 2'h0
`define EQWS_RST_WEIGHT 7'h01
// average sampling period and its cycle count at the core clock
`define EQWS_CLK_PERIOD_NS 10
`define EQWS_AVG_PERIOD_NS 1000
`define EQWS_AVG_CYCLES (`EQWS_AVG_PERIOD_NS / `EQWS_CLK_PERIOD_NS)
// averaging weight as a right shift (1/8 per sample)
`define EQWS_AVG_SHIFT 3
`endif
